// [design/ucb_serial.sv]
// How it works
// - a bad stop bit sets the framing error flag; only software clears it.
// - control bit 7 shows the framing error flag while view select is 1.
// - with view select 0, control bit 7 is the upper mode bit.
// - the two mode bits pick shift, 8-bit, fixed 9-bit or timed 9-bit.
// - 9-bit modes with multiprocessor on drop frames whose ninth bit is 0.
// - 8-bit mode with multiprocessor on drops frames without a good stop.
// - receiving only happens while receive enable is set.
// - the ninth transmitted bit is the software transmit ninth bit.
// - receive ninth bit holds the ninth bit, or the stop bit in 8-bit mode.
// - transmit done sets after bit 8 in shift mode, else at stop start.
// - receive done sets after bit 8 in shift mode, else at mid stop.
// - shift mode runs at one sixth of the clock.
// - fixed 9-bit mode runs at clock over 32, or 16 when doubled.
// - baud double resets to zero.
// - 8-bit and timed 9-bit modes derive rate from timer 1 overflow.
// - any timer 1 mode may feed the overflow pulse used as baud source.
// - shift mode moves 8 bits lsb first on data, clock on transmit pin.
// - 8-bit frames are start 0, eight data lsb first, stop 1.
// - 9-bit frames add the ninth bit before stop; stop ignored for data.
// - shift receive starts on done 0 and enable 1, else on start bit.
`timescale 1ns/1ps
`include "ucb_params.svh"

module ucb_fifo #(
	parameter int W = 9,
	parameter int D = 16
) (
	input wire logic clk,
	input wire logic resetn,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [W-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [W-1:0] out_data
);
	localparam int PW = $clog2(D);
	localparam int CW = PW + 1;
	typedef struct packed {
		logic [D-1:0][W-1:0] mem;
		logic [PW-1:0] wp;
		logic [PW-1:0] rp;
		logic [CW-1:0] cnt;
		logic rdy;
		logic vld;
	} ucb_fifo_s;
	ucb_fifo_s f_q;
	ucb_fifo_s f_d;
	logic push;
	logic pop;
	assign in_ready = f_q.rdy;
	assign out_valid = f_q.vld;
	assign out_data = f_q.mem[f_q.rp];
	always_comb begin
		f_d = f_q;
		push = in_valid & f_q.rdy;
		pop = out_ready & f_q.vld;
		if (push) begin
			f_d.mem[f_q.wp] = in_data;
			f_d.wp = f_q.wp + 1'b1;
		end
		if (pop) begin
			f_d.rp = f_q.rp + 1'b1;
		end
		f_d.cnt = f_q.cnt + CW'(push) - CW'(pop);
		f_d.rdy = f_d.cnt != CW'(D);
		f_d.vld = f_d.cnt != '0;
	end
	always_ff @(posedge clk) begin
		if (!resetn) begin
			f_q <= '0;
			f_q.rdy <= 1'b1;
		end else begin
			f_q <= f_d;
		end
	end
endmodule // ucb_fifo

module ucb_serial
	import ucb_pkg::*;
(
	input wire logic clk,
	input wire logic resetn,
	input wire logic [7:0] sfr_addr,
	input wire logic [7:0] sfr_wdata,
	input wire logic sfr_wr,
	input wire logic sfr_rd,
	output logic [7:0] sfr_rdata,
	input wire logic timer1_overflow,
	input wire logic rxd_in,
	output logic rxd_out,
	output logic rxd_oe,
	output logic txd_out,
	output logic tx_fifo_ready
);
	ucb_state_s s_q;
	ucb_state_s s_d;
	ucb_mode_e mode;
	logic wr_ctrl;
	logic wr_buf;
	logic wr_pwr;
	logic src;
	logic ovs;
	logic f_vld;
	logic f_rdy;
	logic [8:0] f_data;
	logic [1:0] ones_n;
	logic vote;
	logic t_stop;
	logic r_stop;
	logic r_ninth;
	logic [7:0] r_byte;

	assign mode = ucb_mode_e'({s_q.mhi, s_q.mlo});
	assign wr_ctrl = sfr_wr && sfr_addr == `UCB_ADDR_CTRL;
	assign wr_buf = sfr_wr && sfr_addr == `UCB_ADDR_BUF;
	assign wr_pwr = sfr_wr && sfr_addr == `UCB_ADDR_PWR;
	assign f_rdy = s_q.tst == ucb_tx_idle && s_q.rst != ucb_rx_shift;
	assign sfr_rdata = s_q.rdata;
	assign rxd_out = s_q.rxo;
	assign rxd_oe = s_q.rxoe;
	assign txd_out = s_q.txo;

	ucb_fifo #(
		.W(`UCB_FIFO_W),
		.D(`UCB_FIFO_D)
	) u_fifo (
		.clk(clk),
		.resetn(resetn),
		.in_valid(wr_buf),
		.in_ready(tx_fifo_ready),
		.in_data({s_q.tx9, sfr_wdata}),
		.out_valid(f_vld),
		.out_ready(f_rdy),
		.out_data(f_data)
	);

	always_comb begin
		s_d = s_q;
		t_stop = 1'b0;
		r_stop = 1'b0;
		r_ninth = 1'b0;
		r_byte = 8'h00;
		s_d.rprev = rxd_in;
		// oversample tick: 16 per bit time
		src = mode == ucb_m_uart9f ? 1'b1 : timer1_overflow;
		ovs = src & (s_q.dbl | s_q.pre);
		if (src) begin
			s_d.pre = ~s_q.pre;
		end
		ones_n = s_q.ones + {1'b0, rxd_in};
		vote = ones_n[1];
		// register writes, hardware sets below win
		if (wr_ctrl) begin
			if (s_q.view) begin
				s_d.fe = sfr_wdata[`UCB_BIT_B7];
			end else begin
				s_d.mhi = sfr_wdata[`UCB_BIT_B7];
			end
			s_d.mlo = sfr_wdata[`UCB_BIT_MLO];
			s_d.mpe = sfr_wdata[`UCB_BIT_MPE];
			s_d.ren = sfr_wdata[`UCB_BIT_REN];
			s_d.tx9 = sfr_wdata[`UCB_BIT_TX9];
			s_d.rx9 = sfr_wdata[`UCB_BIT_RX9];
			s_d.txd = sfr_wdata[`UCB_BIT_TXD];
			s_d.rxd = sfr_wdata[`UCB_BIT_RXD];
		end
		if (wr_pwr) begin
			s_d.dbl = sfr_wdata[`UCB_BIT_DBL];
			s_d.view = sfr_wdata[`UCB_BIT_VIEW];
		end
		if (sfr_rd) begin
			unique case (sfr_addr)
				`UCB_ADDR_CTRL: s_d.rdata = {s_q.view ? s_q.fe : s_q.mhi,
					s_q.mlo, s_q.mpe, s_q.ren, s_q.tx9, s_q.rx9, s_q.txd, s_q.rxd};
				`UCB_ADDR_BUF: s_d.rdata = s_q.rbuf;
				`UCB_ADDR_PWR: s_d.rdata = {s_q.dbl, s_q.view, 6'h00};
				default: s_d.rdata = 8'h00;
			endcase
		end
		// transmit engine
		unique case (s_q.tst)
			ucb_tx_idle: begin
				s_d.txo = 1'b1;
				if (f_vld && f_rdy) begin
					s_d.tbits = 4'h0;
					s_d.tsub = 4'h0;
					if (mode == ucb_m_shift) begin
						s_d.tst = ucb_tx_shift;
						s_d.tsh = {3'h0, f_data[7:0]};
						s_d.rxo = f_data[0];
						s_d.rxoe = 1'b1;
						s_d.txo = 1'b0;
					end else begin
						s_d.tst = ucb_tx_uart;
						s_d.tsh = {1'b1, s_q.mhi ? f_data[8] : 1'b1,
							f_data[7:0], 1'b0};
						s_d.txo = 1'b0;
					end
				end
			end
			ucb_tx_shift: begin
				s_d.tsub = s_q.tsub + 4'h1;
				if (s_q.tsub == `UCB_M0_LAST) begin
					s_d.tsub = 4'h0;
					s_d.tbits = s_q.tbits + 4'h1;
					s_d.tsh = {1'b0, s_q.tsh[10:1]};
					s_d.rxo = s_q.tsh[1];
					if (s_q.tbits == `UCB_M0_BITS) begin
						s_d.tst = ucb_tx_idle;
						s_d.rxoe = 1'b0;
						t_stop = 1'b1;
					end
				end
				s_d.txo = s_d.tsub >= `UCB_M0_HIGH || s_d.tst == ucb_tx_idle;
			end
			ucb_tx_uart: begin
				if (ovs) begin
					s_d.tsub = s_q.tsub + 4'h1;
					if (s_q.tsub == `UCB_OVS_LAST) begin
						s_d.tbits = s_q.tbits + 4'h1;
						s_d.tsh = {1'b1, s_q.tsh[10:1]};
						s_d.txo = s_q.tsh[1];
						if (s_d.tbits == (s_q.mhi ? `UCB_TX_LAST9 : `UCB_TX_LAST8)) begin
							t_stop = 1'b1;
						end
						if (s_q.tbits == (s_q.mhi ? `UCB_TX_LAST9 : `UCB_TX_LAST8)) begin
							s_d.tst = ucb_tx_idle;
							s_d.txo = 1'b1;
						end
					end
				end
			end
			default: s_d.tst = ucb_tx_idle;
		endcase
		// receive engine
		unique case (s_q.rst)
			ucb_rx_idle: begin
				s_d.rsub = 4'h0;
				s_d.rbits = 4'h0;
				s_d.ones = 2'h0;
				if (s_q.ren && mode == ucb_m_shift) begin
					if (!s_q.rxd && s_q.tst == ucb_tx_idle && !f_vld) begin
						s_d.rst = ucb_rx_shift;
						s_d.txo = 1'b0;
					end
				end else if (s_q.ren && s_q.rprev && !rxd_in) begin
					s_d.rst = ucb_rx_start;
				end
			end
			ucb_rx_shift: begin
				s_d.rsub = s_q.rsub + 4'h1;
				if (s_q.rsub == `UCB_M0_SAMPLE) begin
					s_d.rsh = {rxd_in, s_q.rsh[8:1]};
				end
				if (s_q.rsub == `UCB_M0_LAST) begin
					s_d.rsub = 4'h0;
					s_d.rbits = s_q.rbits + 4'h1;
					if (s_q.rbits == `UCB_M0_BITS) begin
						s_d.rst = ucb_rx_idle;
						s_d.rbuf = s_q.rsh[8:1];
						s_d.rxd = 1'b1;
					end
				end
				s_d.txo = s_d.rsub >= `UCB_M0_HIGH || s_d.rst == ucb_rx_idle;
			end
			ucb_rx_start, ucb_rx_data: begin
				if (ovs) begin
					s_d.rsub = s_q.rsub + 4'h1;
					if (s_q.rsub >= `UCB_VOTE_A && s_q.rsub <= `UCB_VOTE_C) begin
						s_d.ones = ones_n;
					end
					if (s_q.rsub == `UCB_VOTE_C) begin
						s_d.ones = 2'h0;
						if (s_q.rst == ucb_rx_start) begin
							s_d.rst = vote ? ucb_rx_idle : ucb_rx_data;
						end else if (s_q.rbits ==
							(s_q.mhi ? `UCB_RX_LAST9 : `UCB_RX_LAST8)) begin
							r_stop = 1'b1;
							s_d.rst = ucb_rx_idle;
						end else begin
							s_d.rsh = {vote, s_q.rsh[8:1]};
							s_d.rbits = s_q.rbits + 4'h1;
						end
					end
				end
			end
		endcase
		// stop bit at mid point decides the frame
		r_ninth = s_q.mhi ? s_q.rsh[8] : vote;
		r_byte = s_q.mhi ? s_q.rsh[7:0] : s_q.rsh[8:1];
		if (r_stop) begin
			if (!vote) begin
				s_d.fe = 1'b1;
			end
			if (!s_q.rxd && (!s_q.mpe || r_ninth)) begin
				s_d.rbuf = r_byte;
				s_d.rx9 = r_ninth;
				s_d.rxd = 1'b1;
			end
		end
		if (t_stop) begin
			s_d.txd = 1'b1;
		end
		if (!s_q.ren && s_q.rst != ucb_rx_idle) begin
			s_d.rst = ucb_rx_idle;
			s_d.txo = s_q.rst == ucb_rx_shift ? 1'b1 : s_d.txo;
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			s_q <= '0;
			{s_q.mhi, s_q.mlo, s_q.mpe, s_q.ren,
				s_q.tx9, s_q.rx9, s_q.txd, s_q.rxd} <= `UCB_RST_CTRL;
			{s_q.dbl, s_q.view} <= 2'(`UCB_RST_PWR >> 6);
			s_q.txo <= 1'b1;
			s_q.rprev <= 1'b1;
		end else begin
			s_q <= s_d;
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);

	sequence s_clk_low;
		!txd_out [*3];
	endsequence
	sequence s_clk_high;
		txd_out [*3];
	endsequence

	property p_fe_set;
		r_stop && !vote |=> s_q.fe;
	endproperty
	a_fe_set: assert property (p_fe_set) else $error("framing flag not set");

	property p_fe_view;
		sfr_rd && sfr_addr == `UCB_ADDR_CTRL && s_q.view |=> sfr_rdata[7] == $past(s_q.fe);
	endproperty
	a_fe_view: assert property (p_fe_view) else $error("bit 7 not framing flag");

	property p_mode_view;
		sfr_rd && sfr_addr == `UCB_ADDR_CTRL && !s_q.view |=> sfr_rdata[7] == $past(s_q.mhi);
	endproperty
	a_mode_view: assert property (p_mode_view) else $error("bit 7 not mode bit");

	property p_separate;
		wr_ctrl && s_q.view |=> $stable(s_q.mhi);
	endproperty
	a_separate: assert property (p_separate) else $error("mode bit changed");

	property p_mp9;
		r_stop && s_q.mhi && s_q.mpe && !s_q.rsh[8] && !wr_ctrl |=> $stable(s_q.rxd);
	endproperty
	a_mp9: assert property (p_mp9) else $error("address filter failed");

	property p_mp8;
		r_stop && mode == ucb_m_uart8 && s_q.mpe && !vote && !wr_ctrl |=> $stable(s_q.rxd);
	endproperty
	a_mp8: assert property (p_mp8) else $error("stop filter failed");

	property p_ren;
		!s_q.ren |=> s_q.rst == ucb_rx_idle;
	endproperty
	a_ren: assert property (p_ren) else $error("receive while disabled");

	property p_m0_rate;
		s_q.tst == ucb_tx_shift && s_q.tsub == 4'h0 |-> s_clk_low ##1 s_clk_high;
	endproperty
	a_m0_rate: assert property (p_m0_rate) else $error("shift clock not div 6");

	property p_txdone;
		t_stop |=> s_q.txd;
	endproperty
	a_txdone: assert property (p_txdone) else $error("transmit done missing");

	property p_div32;
		mode == ucb_m_uart9f && !s_q.dbl && ovs && !wr_pwr && !wr_ctrl
			|=> !ovs ##1 (ovs || mode != ucb_m_uart9f);
	endproperty
	a_div32: assert property (p_div32) else $error("fixed rate wrong");
endmodule // ucb_serial

// [inc/ucb_params.svh]
`ifndef UCB_PARAMS_SVH
`define UCB_PARAMS_SVH
`define UCB_ADDR_CTRL 8'h98
`define UCB_ADDR_BUF 8'h99
`define UCB_ADDR_PWR 8'h87
`define UCB_BIT_B7 7
`define UCB_BIT_MLO 6
`define UCB_BIT_MPE 5
`define UCB_BIT_REN 4
`define UCB_BIT_TX9 3
`define UCB_BIT_RX9 2
`define UCB_BIT_TXD 1
`define UCB_BIT_RXD 0
`define UCB_BIT_DBL 7
`define UCB_BIT_VIEW 6
`define UCB_RST_CTRL 8'h00
`define UCB_RST_PWR 8'h00
`define UCB_M0_HIGH 4'h3
`define UCB_M0_SAMPLE 4'h4
`define UCB_M0_LAST 4'h5
`define UCB_M0_BITS 4'h7
`define UCB_OVS_LAST 4'hf
`define UCB_VOTE_A 4'h7
`define UCB_VOTE_C 4'h9
`define UCB_TX_LAST8 4'h9
`define UCB_TX_LAST9 4'ha
`define UCB_RX_LAST8 4'h8
`define UCB_RX_LAST9 4'h9
`define UCB_FIFO_W 9
`define UCB_FIFO_D 16
`endif

// [inc/ucb_pkg.sv]
package ucb_pkg;
	typedef enum logic [1:0] {
		ucb_m_shift = 2'b00,
		ucb_m_uart8 = 2'b01,
		ucb_m_uart9f = 2'b10,
		ucb_m_uart9t = 2'b11
	} ucb_mode_e;
	typedef enum logic [1:0] {
		ucb_tx_idle = 2'b00,
		ucb_tx_shift = 2'b01,
		ucb_tx_uart = 2'b10
	} ucb_tx_e;
	typedef enum logic [1:0] {
		ucb_rx_idle = 2'b00,
		ucb_rx_shift = 2'b01,
		ucb_rx_start = 2'b10,
		ucb_rx_data = 2'b11
	} ucb_rx_e;
	typedef struct packed {
		logic mhi;
		logic mlo;
		logic mpe;
		logic ren;
		logic tx9;
		logic rx9;
		logic txd;
		logic rxd;
		logic fe;
		logic dbl;
		logic view;
		logic [7:0] rbuf;
		logic [7:0] rdata;
		logic pre;
		ucb_tx_e tst;
		logic [10:0] tsh;
		logic [3:0] tbits;
		logic [3:0] tsub;
		logic txo;
		logic rxo;
		logic rxoe;
		ucb_rx_e rst;
		logic [8:0] rsh;
		logic [3:0] rbits;
		logic [3:0] rsub;
		logic rprev;
		logic [1:0] ones;
	} ucb_state_s;
endpackage

// [dv/ucb_remote.sv]
`timescale 1ns/1ps
module ucb_remote (
	input wire logic clk,
	input wire logic txd_out,
	input wire logic rxd_out,
	output logic line
);
	initial line = 1'b1;
	// drive one frame lsb first, idle high after
	task automatic send(input logic [10:0] f, input int n, input int bt);
		for (int i = 0; i < n; i++) begin
			@(posedge clk);
			line <= f[i];
			repeat (bt - 1) @(posedge clk);
		end
		@(posedge clk);
		line <= 1'b1;
		repeat (bt) @(posedge clk);
	endtask
	// sample a uart frame at mid bit
	task automatic recv(output logic [10:0] f, input int n, input int bt);
		f = '0;
		do @(posedge clk); while (txd_out !== 1'b0);
		repeat (bt / 2) @(posedge clk);
		for (int i = 0; i < n; i++) begin
			f[i] = txd_out;
			repeat (bt) @(posedge clk);
		end
	endtask
	// capture shift data on rising shift clock
	task automatic shift_recv(output logic [7:0] d, output int per);
		logic prev;
		realtime t;
		per = 0;
		t = 0;
		for (int i = 0; i < 8; i++) begin
			do begin
				prev = txd_out;
				@(posedge clk);
			end while (!(txd_out === 1'b1 && prev === 1'b0));
			d[i] = rxd_out;
			if (i == 1) per = int'(($realtime - t) / 10.0);
			t = $realtime;
		end
	endtask
	// drive shift data on falling shift clock, idle high after
	task automatic shift_send(input logic [7:0] d);
		logic prev;
		for (int i = 0; i < 8; i++) begin
			do begin
				prev = txd_out;
				@(posedge clk);
			end while (!(txd_out === 1'b0 && prev === 1'b1));
			line <= d[i];
		end
		repeat (6) @(posedge clk);
		line <= 1'b1;
	endtask
endmodule // ucb_remote

// [dv/tb.sv]
`timescale 1ns/1ps
module tb;
	logic clk = 1'b0;
	logic resetn;
	logic [7:0] sfr_addr;
	logic [7:0] sfr_wdata;
	logic [7:0] sfr_rdata;
	logic sfr_wr;
	logic sfr_rd;
	logic timer1_overflow;
	logic rxd_out;
	logic rxd_oe;
	logic txd_out;
	logic tx_fifo_ready;
	logic line;
	logic [7:0] r;
	logic [10:0] f;
	int per;
	int num_errors = 0;
	int checks_done = 0;
	int cycles = 0;

	always #5 clk = ~clk;

	ucb_serial ucb_serial_inst (.clk(clk), .resetn(resetn), .sfr_addr(sfr_addr),
		.sfr_wdata(sfr_wdata), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata),
		.timer1_overflow(timer1_overflow), .rxd_in(rxd_oe ? rxd_out : line),
		.rxd_out(rxd_out), .rxd_oe(rxd_oe), .txd_out(txd_out),
		.tx_fifo_ready(tx_fifo_ready));
	ucb_remote ucb_remote_inst (.clk(clk), .txd_out(txd_out), .rxd_out(rxd_out), .line(line));

	// overflow pulse every second clock, no timer interrupt used
	always @(posedge clk) begin
		timer1_overflow <= resetn & ~timer1_overflow;
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			num_errors++;
			test_done();
		end
	end

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		sfr_addr <= a;
		sfr_wdata <= d;
		sfr_wr <= 1'b1;
		@(posedge clk);
		sfr_wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk);
		sfr_addr <= a;
		sfr_rd <= 1'b1;
		@(posedge clk);
		sfr_rd <= 1'b0;
		#1 d = sfr_rdata;
	endtask
	task automatic chk_wire(input string n, input logic [10:0] e, input logic [10:0] g);
		checks_done++;
		if (g !== e) begin
			num_errors++;
			$display("unexpected %s: expected %h seen %h", n, e, g);
		end
	endtask
	task automatic chk_reg(input string n, input logic [7:0] a, input logic [7:0] e);
		logic [7:0] g;
		rd(a, g);
		chk_wire(n, {3'b0, e}, {3'b0, g});
	endtask
	task test_done;
		$display("checks %0d errors %0d", checks_done, num_errors);
		if (num_errors == 0 && checks_done > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	initial begin
		resetn = 1'b0;
		sfr_addr = 8'h00;
		sfr_wdata = 8'h00;
		sfr_wr = 1'b0;
		sfr_rd = 1'b0;
		timer1_overflow = 1'b0;
		repeat (5) @(posedge clk);
		resetn <= 1'b1;
		chk_reg("control reset", 8'h98, 8'h00);
		chk_reg("power reset", 8'h87, 8'h00);
		chk_reg("unmapped read", 8'h55, 8'h00);
		chk_wire("fifo ready", 11'h001, {10'b0, tx_fifo_ready});
		$display("test reset finished");
		wr(8'h98, 8'h88);
		wr(8'h99, 8'hc6);
		ucb_remote_inst.recv(f, 11, 32);
		chk_wire("mode2 slow frame", {2'b11, 8'hc6, 1'b0}, f);
		chk_reg("tx done", 8'h98, 8'h8a);
		wr(8'h87, 8'h80);
		chk_reg("power double", 8'h87, 8'h80);
		wr(8'h98, 8'h80);
		wr(8'h99, 8'h3a);
		ucb_remote_inst.recv(f, 11, 16);
		chk_wire("mode2 fast frame", {2'b10, 8'h3a, 1'b0}, f);
		chk_reg("tx done fast", 8'h98, 8'h82);
		$display("test mode2 transmit finished");
		wr(8'h98, 8'h50);
		ucb_remote_inst.send({2'b11, 8'h3c, 1'b0}, 10, 32);
		chk_reg("mode1 buffer", 8'h99, 8'h3c);
		chk_reg("mode1 control", 8'h98, 8'h55);
		wr(8'h98, 8'h40);
		ucb_remote_inst.send({2'b11, 8'h5a, 1'b0}, 10, 32);
		chk_reg("receive off", 8'h98, 8'h40);
		$display("test mode1 receive finished");
		wr(8'h98, 8'h70);
		ucb_remote_inst.send({2'b10, 8'h5a, 1'b0}, 10, 32);
		chk_reg("bad stop filtered", 8'h98, 8'h70);
		wr(8'h87, 8'hc0);
		chk_reg("framing view", 8'h98, 8'hf0);
		wr(8'h87, 8'h80);
		chk_reg("mode view", 8'h98, 8'h70);
		wr(8'h87, 8'hc0);
		wr(8'h98, 8'h70);
		chk_reg("framing cleared", 8'h98, 8'h70);
		wr(8'h87, 8'h80);
		$display("test framing finished");
		wr(8'h98, 8'hf0);
		ucb_remote_inst.send({2'b10, 8'h81, 1'b0}, 11, 32);
		chk_reg("ninth zero filtered", 8'h98, 8'hf0);
		ucb_remote_inst.send({2'b11, 8'h81, 1'b0}, 11, 32);
		chk_reg("ninth one taken", 8'h98, 8'hf5);
		chk_reg("mode3 buffer", 8'h99, 8'h81);
		$display("test multiprocessor finished");
		wr(8'h98, 8'h00);
		fork
			begin
				for (int i = 0; i < 17; i++) wr(8'h99, 8'h96 + 8'(i));
				#1 chk_wire("fifo full", 11'h000, {10'b0, tx_fifo_ready});
				wr(8'h99, 8'hff);
			end
			for (int i = 0; i < 17; i++) begin
				ucb_remote_inst.shift_recv(r, per);
				chk_wire("shift data", {3'b0, 8'h96 + 8'(i)}, {3'b0, r});
				if (i == 0) chk_wire("shift period", 11'd6, 11'(per));
			end
		join
		repeat (20) @(posedge clk);
		#1 chk_wire("drained idle", 11'h002, {9'b0, tx_fifo_ready, rxd_oe});
		chk_reg("shift done", 8'h98, 8'h02);
		$display("test shift transmit finished");
		wr(8'h98, 8'h10);
		ucb_remote_inst.shift_send(8'ha5);
		chk_reg("shift rx buffer", 8'h99, 8'ha5);
		chk_reg("shift rx done", 8'h98, 8'h11);
		$display("test shift receive finished");
		test_done();
	end
endmodule // tb
